/* File: logic/fpc_pkg.sv */
// constants and types for the frequency and period counter block
// What this block does
// - three 16-bit down-counters, each with its own clock enable and gate.
// - a counter decrements on its clock only while its gate is open.
// - in frequency mode the counter is preloaded with FFFF before the gate.
// - the frequency gate stays open for a selectable known time.
// - gate times of 10, 1, 0.1, 0.01 and 0.001 seconds are offered.
// - end of the frequency gate raises an end-of-count interrupt.
// - a wrap of counter zero during the frequency gate interrupts and counting carries on.
// - period mode uses all counters, counters one and two on 10 MHz.
// - counter one counts the input low phase, counter two the high phase.
// - counter zero counts overflows of counters one and two.
// - period mode signals end of count once per measured input cycle.
// - all counter values are readable directly by the processor.
// - each interrupt source is maskable, delivered as a level-3 vector.
// - the counter request waits and never preempts a level-3 service.
// - an acknowledge cycle returns the vector from a status register.
// - a mask bit per source suppresses that request.
package fpc_pkg;

    // ------------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W       = 16;
    localparam logic [15:0] FULL_COUNT  = 16'hFFFF;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned TB_HZ       = 10_000_000;
    localparam int unsigned TB_DIV      = CLK_HZ / TB_HZ;
    localparam logic [3:0]  TB_LAST     = 4'(TB_DIV - 1);
    localparam int unsigned GATE_US_MIN = 1;
    localparam int unsigned US_CYC      = CLK_HZ / 1_000_000 * GATE_US_MIN;
    localparam logic [6:0]  US_LAST     = 7'(US_CYC - 1);
    localparam logic [23:0] G10_US      = 24'h989680; // 10 s
    localparam logic [23:0] G1_US       = 24'h0F4240; // 1 s
    localparam logic [23:0] G100M_US    = 24'h0186A0; // 0.1 s
    localparam logic [23:0] G10M_US     = 24'h002710; // 0.01 s
    localparam logic [23:0] G1M_US      = 24'h0003E8; // 0.001 s
    localparam logic [23:0] G1U_US      = 24'h000001; // 1 us
    localparam logic [7:0]  VEC_BASE    = 8'h40;      // arbitrary

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FPC_G10 = 3'h0, FPC_G1 = 3'h1, FPC_G100M = 3'h2,
        FPC_G10M = 3'h3, FPC_G1M = 3'h4, FPC_G1U = 3'h5
    } fpc_gate_sel_t;

    typedef enum logic [3:0] {
        FPC_IDLE  = 4'b0001,
        FPC_GATE  = 4'b0010,
        FPC_SYNC  = 4'b0100,
        FPC_HOLD  = 4'b1000
    } fpc_state_t;

    typedef struct packed {
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
    } fpc_counts_t;

    typedef struct packed {
        logic        ovf;
        logic        eoc;
    } fpc_irq_t;

    function automatic logic [23:0] fpc_gate_us(input logic [2:0] sel);
        unique case (sel)
            3'h0:    return G10_US;
            3'h1:    return G1_US;
            3'h2:    return G100M_US;
            3'h3:    return G10M_US;
            3'h4:    return G1M_US;
            default: return G1U_US;
        endcase
    endfunction

endpackage

/* File: logic/fpc_down_counter.sv */
// one gated 16-bit down-counter with load and wrap flag
`timescale 1ns/10ps
module fpc_down_counter
    import fpc_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    // control
    input  wire logic              i_load,
    input  wire logic [CNT_W-1:0]  i_load_val,
    input  wire logic              i_tick,
    input  wire logic              i_gate,
    // state
    output logic [CNT_W-1:0]       o_count,
    output logic                   o_wrap
);
    logic [CNT_W-1:0] next_count;
    logic             next_wrap;

    always_comb begin
        next_count = o_count;
        next_wrap  = 1'b0;
        if (i_load) begin
            next_count = i_load_val;
        end else if (i_tick && i_gate) begin
            next_count = o_count - 16'h0001;
            next_wrap  = (o_count == 16'h0000);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= 16'h0000;
            o_wrap  <= 1'b0;
        end else begin
            o_count <= next_count;
            o_wrap  <= next_wrap;
        end
    end

    chk_hold_closed: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!i_load && !(i_tick && i_gate)) |=> $stable(o_count))
        else $error("counter moved with gate closed");
    chk_dec_open: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!i_load && i_tick && i_gate) |=>
        o_count == 16'($past(o_count) - 16'h0001))
        else $error("counter did not decrement");
endmodule

/* File: logic/fpc_freq_period.sv */
// frequency and period measurement block top
`timescale 1ns/10ps
module fpc_freq_period
    import fpc_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    // measured signal, asynchronous pin
    input  wire logic              i_sig,
    // processor control
    input  wire logic              i_period_mode,
    input  wire logic [2:0]        i_gate_sel,
    input  wire logic              i_start,
    input  wire logic              i_read_done,
    input  wire logic [1:0]        i_irq_mask,
    input  wire logic              i_clr_ovf,
    input  wire logic              i_clr_eoc,
    // level-3 interrupt handshake
    input  wire logic              i_iack,
    input  wire logic              i_l3_busy,
    // results
    output fpc_counts_t            o_counts,
    output fpc_irq_t               o_irq_stat,
    output logic                   o_busy,
    output logic                   o_irq_l3,
    output logic [7:0]             o_vector
);
    // ------------------------------------------------------------------
    // input synchroniser, three stages
    // ------------------------------------------------------------------
    logic [2:0] sig_sync;
    logic       sig_lvl;
    logic       next_sig_lvl;

    always_comb begin
        next_sig_lvl = sig_lvl;
        if (sig_sync[1] == sig_sync[2]) begin
            next_sig_lvl = sig_sync[2];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sig_sync <= 3'h0;
            sig_lvl  <= 1'b0;
        end else begin
            sig_sync <= {sig_sync[1:0], i_sig};
            sig_lvl  <= next_sig_lvl;
        end
    end

    logic sig_prev;
    logic sig_rise;
    assign sig_rise = sig_lvl && !sig_prev;

    // ------------------------------------------------------------------
    // 10 MHz timebase and 1 us tick
    // ------------------------------------------------------------------
    logic [3:0]  tb_cnt;
    logic [6:0]  us_cnt;
    logic        tb_tick;
    logic        us_tick;
    logic [3:0]  next_tb_cnt;
    logic [6:0]  next_us_cnt;
    logic        load;

    assign tb_tick = (tb_cnt == TB_LAST);
    assign us_tick = (us_cnt == US_LAST);

    always_comb begin
        next_tb_cnt = tb_tick ? 4'h0 : tb_cnt + 4'h1;
        // restart on a start, else the gate jitters by up to one us
        next_us_cnt = (us_tick || load) ? 7'h00 : us_cnt + 7'h01;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tb_cnt   <= 4'h0;
            us_cnt   <= 7'h00;
            sig_prev <= 1'b0;
        end else begin
            tb_cnt   <= next_tb_cnt;
            us_cnt   <= next_us_cnt;
            sig_prev <= sig_lvl;
        end
    end

    // ------------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------------
    fpc_state_t  state;
    fpc_state_t  next_state;
    logic        mode;
    logic        next_mode;
    logic [23:0] gate_left;
    logic [23:0] next_gate_left;
    logic        done;

    always_comb begin
        next_state     = state;
        next_mode      = mode;
        next_gate_left = gate_left;
        load           = 1'b0;
        done           = 1'b0;
        unique case (state)
            FPC_IDLE: begin
                if (i_start) begin
                    load      = 1'b1;
                    next_mode = i_period_mode;
                    next_gate_left = fpc_gate_us(i_gate_sel);
                    next_state = i_period_mode ? FPC_SYNC : FPC_GATE;
                end
            end
            FPC_GATE: begin
                if (us_tick && !mode) begin
                    next_gate_left = gate_left - 24'h000001;
                    if (gate_left == 24'h000001) begin
                        done       = 1'b1;
                        next_state = FPC_HOLD;
                    end
                end
            end
            FPC_SYNC: begin
                // wait for a rising edge, then one full cycle to the next
                if (sig_rise) begin
                    next_state = FPC_GATE;
                end
            end
            FPC_HOLD: begin
                if (i_read_done) begin
                    next_state = FPC_IDLE;
                end
            end
        endcase
        if (mode && state == FPC_GATE) begin
            next_gate_left = gate_left;
            if (sig_rise) begin
                done       = 1'b1;
                next_state = FPC_HOLD;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state     <= FPC_IDLE;
            mode      <= 1'b0;
            gate_left <= 24'h000000;
        end else begin
            state     <= next_state;
            mode      <= next_mode;
            gate_left <= next_gate_left;
        end
    end

    assign o_busy = (state != FPC_IDLE);

    // ------------------------------------------------------------------
    // the three counters
    // ------------------------------------------------------------------
    logic        open;
    logic [2:0]  tick;
    logic [2:0]  gate;
    logic [2:0]  wrap;
    logic [15:0] cnt [3];

    assign open = (state == FPC_GATE);

    always_comb begin
        if (mode) begin
            tick    = {tb_tick, tb_tick, wrap[1] || wrap[2]};
            gate[0] = open;
            gate[1] = open && !sig_lvl;
            gate[2] = open && sig_lvl;
        end else begin
            // frequency mode uses counter zero only
            tick    = {1'b0, 1'b0, sig_rise};
            gate    = {1'b0, 1'b0, open};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            fpc_down_counter u_cnt (
                .i_sys_clk  (i_sys_clk),
                .i_rst      (i_rst),
                .i_load     (load),
                .i_load_val (FULL_COUNT),
                .i_tick     (tick[gi]),
                .i_gate     (gate[gi]),
                .o_count    (cnt[gi]),
                .o_wrap     (wrap[gi])
            );
        end
    endgenerate

    // registered, so a read sees a settled value
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_counts <= '0;
        end else begin
            o_counts <= '{cnt0: cnt[0], cnt1: cnt[1], cnt2: cnt[2]};
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and vector
    // ------------------------------------------------------------------
    fpc_irq_t next_irq_stat;
    logic     ovf_ev;
    logic     pend;
    logic     next_irq_l3;
    logic [7:0] next_vector;

    assign ovf_ev = !mode && wrap[0];

    always_comb begin
        next_irq_stat = o_irq_stat;
        if (i_clr_ovf) next_irq_stat.ovf = 1'b0;
        if (i_clr_eoc) next_irq_stat.eoc = 1'b0;
        // set wins over a clear in the same cycle
        if (ovf_ev) next_irq_stat.ovf = 1'b1;
        if (done)   next_irq_stat.eoc = 1'b1;
    end

    assign pend = (o_irq_stat.ovf && !i_irq_mask[1]) ||
                  (o_irq_stat.eoc && !i_irq_mask[0]);

    always_comb begin
        // no new request while another level-3 service runs
        next_irq_l3 = pend && !i_l3_busy;
        next_vector = o_vector;
        if (i_iack) begin
            next_vector = VEC_BASE |
                {6'h00, o_irq_stat.ovf && !i_irq_mask[1],
                 o_irq_stat.eoc && !i_irq_mask[0]};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_stat <= '0;
            o_irq_l3   <= 1'b0;
            o_vector   <= 8'h00;
        end else begin
            o_irq_stat <= next_irq_stat;
            o_irq_l3   <= next_irq_l3;
            o_vector   <= next_vector;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_eoc_set: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        done |=> o_irq_stat.eoc)
        else $error("end of count not flagged");
    chk_ovf_set: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!mode && wrap[0]) |=> o_irq_stat.ovf)
        else $error("overflow not flagged");
    chk_mask_gate: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_irq_mask == 2'h3) |=> !o_irq_l3)
        else $error("masked request raised");
    chk_no_preempt: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_l3_busy |=> !o_irq_l3)
        else $error("request during level-3 service");
    chk_hold_stable: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == FPC_HOLD && !i_read_done) |=> ##1 $stable(o_counts))
        else $error("counts moved before read");
    chk_preload_full: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        load |=> cnt[0] == FULL_COUNT)
        else $error("preload missing");
    chk_tb_rate: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        tb_tick |=> !tb_tick [*8] ##1 !tb_tick ##1 tb_tick)
        else $error("timebase not 10 MHz");
    chk_period_split: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode && open && tb_tick && sig_lvl) |=> $stable(cnt[1]))
        else $error("low counter ran in high phase");
    chk_gate_restart: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        load |=> us_cnt == 7'h00)
        else $error("gate timer not restarted");
    chk_freq_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!mode && open) |=> $stable(cnt[1]) && $stable(cnt[2]))
        else $error("unused counter moved");

    cov_freq_done: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        done && !mode);
    cov_period_done: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        done && mode);
    cov_ovf: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        ovf_ev);
    cov_iack: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        i_iack && o_irq_l3);
endmodule

/* File: verification/fpc_host_model.sv */
// host processor model that answers level-3 requests of the counter block
`timescale 1ns/10ps
module fpc_host_model
    import fpc_pkg::*;
(
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // bench control
    input  wire logic       i_en,
    input  wire logic       i_ext_busy,
    // level-3 handshake
    input  wire logic       i_irq_l3,
    input  wire logic [7:0] i_vector,
    output logic            o_iack,
    output logic            o_clr_ovf,
    output logic            o_clr_eoc,
    output logic            o_l3_busy,
    // service record
    output int              o_eoc_seen,
    output int              o_ovf_seen,
    output logic [7:0]      o_last_vec
);
    logic svc;

    // one service at a time: a nested level-3 entry is never taken
    assign o_l3_busy = svc | i_ext_busy;

    initial begin
        svc = 1'b0;
        o_iack = 1'b0;
        o_clr_ovf = 1'b0;
        o_clr_eoc = 1'b0;
        o_eoc_seen = 0;
        o_ovf_seen = 0;
        o_last_vec = 8'h00;
        forever begin
            @(posedge i_sys_clk);
            if (!i_rst && i_en && i_irq_l3 === 1'b1 && !o_l3_busy) begin
                #1;
                o_iack = 1'b1;
                svc = 1'b1;
                @(posedge i_sys_clk);
                #1;
                o_iack = 1'b0;
                o_last_vec = i_vector;
                o_clr_ovf = i_vector[1];
                o_clr_eoc = i_vector[0];
                o_ovf_seen += int'(i_vector[1]);
                o_eoc_seen += int'(i_vector[0]);
                @(posedge i_sys_clk);
                #1;
                o_clr_ovf = 1'b0;
                o_clr_eoc = 1'b0;
                // stay busy until the registered request has dropped
                repeat (4) @(posedge i_sys_clk);
                #1;
                svc = 1'b0;
            end
        end
    end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the frequency and period counter block
`timescale 1ns/10ps
module tb
    import fpc_pkg::*;
;
    logic        clk, rst, sig, sig_on, pmode, start, rdone, xbusy;
    logic [2:0]  gsel;
    logic [1:0]  mask;
    logic        iack, clr_ovf, clr_eoc, l3_busy, busy, irq;
    logic [7:0]  vec, lvec;
    logic [15:0] d1, d2;
    fpc_counts_t cnt, snap;
    fpc_irq_t    stat;
    int          err_total, total_checks, eoc_seen, ovf_seen;
    int          hi_ns, lo_ns, prev, c;

    fpc_freq_period uut (
        .i_sys_clk(clk), .i_rst(rst), .i_sig(sig),
        .i_period_mode(pmode), .i_gate_sel(gsel), .i_start(start),
        .i_read_done(rdone), .i_irq_mask(mask), .i_clr_ovf(clr_ovf),
        .i_clr_eoc(clr_eoc), .i_iack(iack), .i_l3_busy(l3_busy),
        .o_counts(cnt), .o_irq_stat(stat), .o_busy(busy),
        .o_irq_l3(irq), .o_vector(vec));

    fpc_host_model host (
        .i_sys_clk(clk), .i_rst(rst), .i_en(1'b1), .i_ext_busy(xbusy),
        .i_irq_l3(irq), .i_vector(vec), .o_iack(iack),
        .o_clr_ovf(clr_ovf), .o_clr_eoc(clr_eoc), .o_l3_busy(l3_busy),
        .o_eoc_seen(eoc_seen), .o_ovf_seen(ovf_seen), .o_last_vec(lvec));

    always #5 clk = ~clk;

    // measured signal edges land on clock falling edges, in 10 ns steps
    always begin
        if (sig_on) begin
            sig = 1'b1;
            #(hi_ns);
            sig = 1'b0;
            #(lo_ns);
        end else begin
            sig = 1'b0;
            #10;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_eoc(input int lim);
        c = 0;
        while (stat.eoc !== 1'b1) begin
            tick(1);
            c++;
            if (c > lim) begin
                check(1'b0, "end of count missing");
                test_done();
            end
        end
    endtask

    task automatic wait_svc();
        for (int i = 0; i < 12 && eoc_seen == prev; i++) tick(1);
        check(eoc_seen == prev + 1, "request not serviced once");
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            tick(1);
            if (irq !== 1'b0) seen = 1'b1;
        end
        check(!seen, "request not held back");
    endtask

    task automatic run(input logic m, input logic [2:0] s);
        prev = eoc_seen;
        pmode = m;
        gsel = s;
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask

    task automatic finish_run();
        sig_on = 1'b0;
        rdone = 1'b1;
        tick(1);
        rdone = 1'b0;
        tick(1);
        check(busy === 1'b0, "hold not released");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check(cnt === '0 && stat === '0 && vec === 8'h00, "reset values");
        check(busy === 1'b0 && irq === 1'b0, "reset flags");
        $display("test reset done");
    endtask

    task automatic t_freq();
        hi_ns = 40;
        lo_ns = 40;
        sig_on = 1'b1;
        run(1'b0, 3'h5);
        check(busy === 1'b1, "not busy after start");
        tick(1);
        check(cnt === {3{FULL_COUNT}}, "no full preload");
        wait_eoc(120);
        check(c >= 97 && c <= 102, "gate length off");
        tick(1);
        check(irq === 1'b1, "no request after gate");
        wait_svc();
        check(lvec === (VEC_BASE | 8'h01), "wrong vector");
        d1 = FULL_COUNT - cnt.cnt0;
        check(d1 inside {[11:14]}, "input cycles off");
        check(cnt.cnt1 === FULL_COUNT, "idle counter moved");
        check(cnt.cnt2 === FULL_COUNT, "idle counter moved");
        snap = cnt;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(20);
        check(cnt === snap && busy === 1'b1, "hold broken");
        finish_run();
        $display("test freq done");
    endtask

    task automatic t_mask();
        mask = 2'b11;
        run(1'b0, 3'h5);
        wait_eoc(120);
        quiet(5);
        mask = 2'b01;
        quiet(5);
        mask = 2'b00;
        wait_svc();
        check(cnt.cnt0 === FULL_COUNT, "count with no input");
        finish_run();
        $display("test mask done");
    endtask

    task automatic t_busy();
        xbusy = 1'b1;
        run(1'b0, 3'h5);
        wait_eoc(120);
        quiet(10);
        xbusy = 1'b0;
        wait_svc();
        check(lvec === (VEC_BASE | 8'h01), "wrong vector");
        finish_run();
        $display("test busy done");
    endtask

    task automatic t_period();
        hi_ns = 600;
        lo_ns = 400;
        sig_on = 1'b1;
        run(1'b1, 3'h0);
        tick(1);
        check(cnt === {3{FULL_COUNT}}, "no full preload");
        wait_eoc(400);
        tick(1);
        d1 = FULL_COUNT - cnt.cnt1;
        d2 = FULL_COUNT - cnt.cnt2;
        check(d1 inside {[3:5]}, "low phase off");
        check(d2 inside {[5:7]}, "high phase off");
        check(d1 + d2 inside {[9:11]}, "period off");
        check(cnt.cnt0 === FULL_COUNT, "false overflow");
        wait_svc();
        snap = cnt;
        tick(300);
        check(eoc_seen == prev + 1, "extra end of count");
        check(cnt === snap, "hold broken");
        finish_run();
        $display("test period done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sig_on = 1'b0;
        pmode = 1'b0;
        start = 1'b0;
        rdone = 1'b0;
        xbusy = 1'b0;
        gsel = 3'h5;
        mask = 2'b00;
        err_total = 0;
        total_checks = 0;
        hi_ns = 40;
        lo_ns = 40;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_freq();
        t_mask();
        t_busy();
        t_period();
        test_done();
    end
endmodule
